// File: olsd_pkg.sv
package olsd_pkg;

  localparam int NUM_CH = 5;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Register addresses (register numbers, one per word).
  localparam logic [4:0] ADDR_QUICK = 5'h01;
  localparam logic [4:0] ADDR_CH_FIRST = 5'h02;
  localparam logic [4:0] ADDR_CH_LAST = 5'h06;
  localparam logic [4:0] ADDR_DEVICE = 5'h07;
  localparam logic [4:0] ADDR_IO = 5'h08;
  localparam logic [4:0] ADDR_LED_CTRL = 5'h0d;
  localparam logic [4:0] ADDR_OFF_TEST = 5'h0e;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0f;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h10;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h11;

  // Field positions.
  localparam int BIT_OFF_OPEN = 0;
  localparam int BIT_ON_OPEN = 1;
  localparam int BIT_OVERCURRENT = 2;
  localparam int BIT_THERM_WARN = 5;
  localparam int BIT_THERM_SHUT = 6;
  localparam int BIT_GLOBAL_OPEN = 8;
  localparam int BIT_GLOBAL_OVERLOAD = 9;
  localparam int BIT_GLOBAL_DEVICE = 10;
  localparam int BIT_SUPPLY_LOW = 2;
  localparam int BIT_LED_TRIGGER = 5;
  localparam int BIT_IRQ_TEST_DONE = 5;
  localparam int IRQ_W = 6;

  // Reset values.
  localparam logic [4:0] RST_LED_ENABLE = 5'h00;
  localparam logic [5:0] RST_IRQ_ENABLE = 6'h00;

  // Least PWM duty for a valid on-state result, per frequency range.
  localparam logic [7:0] DUTY_MIN_LOW_MED = 8'h12;
  localparam logic [7:0] DUTY_MIN_HIGH = 8'h11;
  localparam logic [1:0] FREQ_RANGE_HIGH = 2'h2;

  // Off-state test window.
  localparam int CLK_PERIOD_NS = 100;
  localparam int OFF_TEST_WINDOW_NS = 1200000;
  localparam int OFF_TEST_CYCLES = OFF_TEST_WINDOW_NS / CLK_PERIOD_NS;
  localparam int TEST_CNT_W = 14;

  typedef enum logic {
    OLSD_TEST_IDLE = 1'b0,
    OLSD_TEST_RUN = 1'b1
  } olsd_test_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } olsd_bus_req_t;

  // Analog comparator results, asynchronous to core_clk.
  typedef struct packed {
    logic [NUM_CH-1:0] below_on_thr;
    logic [NUM_CH-1:0] below_led_thr;
    logic [NUM_CH-1:0] below_off_thr;
    logic [NUM_CH-1:0] half_supply_comparator;
    logic supply_low_flag;
  } olsd_analog_t;

  // Latched protection flags from neighbouring logic on core_clk.
  typedef struct packed {
    logic [NUM_CH-1:0][2:0] overcurrent;
    logic [NUM_CH-1:0] thermal_warn;
    logic [NUM_CH-1:0] thermal_shut;
  } olsd_fault_t;

  // Output control state from the PWM logic on core_clk.
  typedef struct packed {
    logic [NUM_CH-1:0] on;
    logic [NUM_CH-1:0] full_on;
    logic [NUM_CH-1:0] turn_off;
    logic [NUM_CH-1:0][7:0] duty;
    logic [1:0] freq_range;
  } olsd_chan_ctl_t;

endpackage

// File: olsd_diag.sv
`timescale 1ns/1ps
`default_nettype none
module olsd_diag #(
  parameter int OFF_TEST_LEN = olsd_pkg::OFF_TEST_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire olsd_pkg::olsd_bus_req_t bus_req,
  output logic [olsd_pkg::DATA_W-1:0] bus_rdata,
  input wire olsd_pkg::olsd_analog_t analog_in,
  input wire olsd_pkg::olsd_fault_t fault_in,
  input wire olsd_pkg::olsd_chan_ctl_t chan_ctl,
  output logic [olsd_pkg::NUM_CH-1:0] test_drive,
  output logic irq
);
  import olsd_pkg::*;

  localparam logic [TEST_CNT_W-1:0] TEST_LAST =
    TEST_CNT_W'(OFF_TEST_LEN - 1);

  olsd_analog_t sync1_q;
  olsd_analog_t ana_q;
  logic [NUM_CH-1:0] on_open_flag_q;
  logic [NUM_CH-1:0] off_state_open_flag_q;
  logic [NUM_CH-1:0] on_open_live_q;
  logic [NUM_CH-1:0] off_open_live_q;
  logic [NUM_CH-1:0] led_open_detect_enable_q;
  logic led_open_check_trigger_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_enable_q;
  logic [DATA_W-1:0] rdata_q;
  olsd_test_t test_state_q [NUM_CH];
  logic [TEST_CNT_W-1:0] test_cnt_q [NUM_CH];
  logic [NUM_CH-1:0] test_pass;
  logic [NUM_CH-1:0] test_fail;
  logic [NUM_CH-1:0] on_check;
  logic [NUM_CH-1:0] on_below;
  logic [NUM_CH-1:0] duty_ok;
  logic [NUM_CH-1:0] ch_read;
  logic [NUM_CH-1:0] off_test_start;
  logic [NUM_CH-1:0] channel_summary_flag;
  logic [NUM_CH-1:0] overload;
  logic [NUM_CH-1:0] test_run;
  logic global_open_flag;
  logic global_overload;
  logic [2:0] global_flags;
  logic [IRQ_W-1:0] irq_event;
  logic [DATA_W-1:0] rdata_d;

  // Two flip-flops on every comparator input; the first stage is read only
  // by the second, so a metastable level never reaches the check logic.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync1_q <= '0;
      ana_q <= '0;
    end else begin
      sync1_q <= analog_in;
      ana_q <= sync1_q;
    end
  end

  // One-cycle decodes of bus accesses.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ch_read[i] = bus_req.rd &&
        (bus_req.addr == ADDR_CH_FIRST + ADDR_W'(i));
      off_test_start[i] = bus_req.wr && (bus_req.addr == ADDR_OFF_TEST) &&
        bus_req.wdata[i];
    end
  end

  // The one-shot trigger is rebuilt every cycle, so it never stays set and
  // a stale request cannot fire a second comparison.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      led_open_check_trigger_q <= 1'b0;
    end else begin
      led_open_check_trigger_q <= bus_req.wr &&
        (bus_req.addr == ADDR_LED_CTRL) &&
        bus_req.wdata[BIT_LED_TRIGGER];
    end
  end

  // LED-mode enables, one per channel, written beside the trigger.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      led_open_detect_enable_q <= RST_LED_ENABLE;
    end else if (bus_req.wr && bus_req.addr == ADDR_LED_CTRL) begin
      led_open_detect_enable_q <= bus_req.wdata[NUM_CH-1:0];
    end
  end

  // On-state check: the threshold and the sampling moment depend on the
  // LED enable and on whether the output runs full on or PWM. In PWM the
  // current is only meaningful late in the on phase, hence turn-off sampling.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (chan_ctl.freq_range == FREQ_RANGE_HIGH) begin
        duty_ok[i] = chan_ctl.duty[i] >= DUTY_MIN_HIGH;
      end else begin
        duty_ok[i] = chan_ctl.duty[i] >= DUTY_MIN_LOW_MED;
      end
      if (led_open_detect_enable_q[i]) begin
        on_below[i] = ana_q.below_led_thr[i];
        if (chan_ctl.full_on[i]) begin
          on_check[i] = chan_ctl.on[i] && led_open_check_trigger_q;
        end else begin
          on_check[i] = chan_ctl.on[i] && chan_ctl.turn_off[i] &&
            duty_ok[i];
        end
      end else begin
        on_below[i] = ana_q.below_on_thr[i];
        on_check[i] = chan_ctl.on[i] &&
          (chan_ctl.full_on[i] || (chan_ctl.turn_off[i] && duty_ok[i]));
      end
    end
  end

  // Result of the last on-state comparison; a read uses it to tell
  // whether the open-load condition has gone.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      on_open_live_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (on_check[i]) begin
          on_open_live_q[i] <= on_below[i];
        end
      end
    end
  end

  // On-state flag: a detection sets it, and a read of the channel word
  // clears it only when the last comparison found the load present.
  // A detection in the read cycle wins over the clear.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      on_open_flag_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (on_check[i] && on_below[i]) begin
          on_open_flag_q[i] <= 1'b1;
        end else if (ch_read[i] && !on_open_live_q[i]) begin
          on_open_flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // Off-state test per channel. A write while the output is commanded on
  // is ignored, since the test current would be swamped by the load.
  // A write while a test already runs is ignored as well.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_CH; i++) begin
        test_state_q[i] <= OLSD_TEST_IDLE;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        unique case (test_state_q[i])
          OLSD_TEST_IDLE: begin
            if (off_test_start[i] && !chan_ctl.on[i]) begin
              test_state_q[i] <= OLSD_TEST_RUN;
            end
          end
          OLSD_TEST_RUN: begin
            if (test_fail[i] || test_pass[i]) begin
              test_state_q[i] <= OLSD_TEST_IDLE;
            end
          end
        endcase
      end
    end
  end

  // Window counter: counts run cycles and sits at zero while idle, so
  // every test starts its window from the same point.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_CH; i++) begin
        test_cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (test_run[i]) begin
          test_cnt_q[i] <= test_cnt_q[i] + 1'b1;
        end else begin
          test_cnt_q[i] <= '0;
        end
      end
    end
  end

  // Test outcome: current above threshold ends the window at once.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      test_run[i] = test_state_q[i] == OLSD_TEST_RUN;
      test_fail[i] = test_run[i] && !ana_q.below_off_thr[i];
      test_pass[i] = test_run[i] && ana_q.below_off_thr[i] &&
        (test_cnt_q[i] == TEST_LAST);
    end
  end

  // The output is driven for the whole window and released combinationally
  // on an early current rise, so it drops in the very cycle it is seen.
  assign test_drive = test_run & ~test_fail;

  // Last verdict of the off-state test; a read uses it to tell whether
  // the open load has gone.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      off_open_live_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (test_pass[i]) begin
          off_open_live_q[i] <= 1'b1;
        end else if (test_fail[i]) begin
          off_open_live_q[i] <= 1'b0;
        end
      end
    end
  end

  // Off-state flag: untouched while a test runs, written by the verdict,
  // and cleared by a read only when the last verdict found the load.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      off_state_open_flag_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (test_pass[i]) begin
          off_state_open_flag_q[i] <= 1'b1;
        end else if (test_fail[i]) begin
          off_state_open_flag_q[i] <= 1'b0;
        end else if (ch_read[i] && !off_open_live_q[i] && !test_run[i]) begin
          off_state_open_flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // Summary, global open and global overload flags follow the latched bits, so they fall only
  // once every underlying bit has been cleared.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      overload[i] = |fault_in.overcurrent[i] || fault_in.thermal_shut[i];
      channel_summary_flag[i] = overload[i] || fault_in.thermal_warn[i] ||
        on_open_flag_q[i] || off_state_open_flag_q[i];
    end
    global_open_flag = |(on_open_flag_q | off_state_open_flag_q);
    global_overload = |overload;
    global_flags = {ana_q.supply_low_flag, global_overload, global_open_flag};
  end

  // Read mux; the global flags appear in every word from one to seven.
  always_comb begin
    rdata_d = '0;
    if (bus_req.addr >= ADDR_QUICK && bus_req.addr <= ADDR_DEVICE) begin
      rdata_d[BIT_GLOBAL_DEVICE:BIT_GLOBAL_OPEN] = global_flags;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (bus_req.addr == ADDR_CH_FIRST + ADDR_W'(i)) begin
        rdata_d[BIT_OFF_OPEN] = off_state_open_flag_q[i];
        rdata_d[BIT_ON_OPEN] = on_open_flag_q[i];
        rdata_d[BIT_OVERCURRENT +: 3] = fault_in.overcurrent[i];
        rdata_d[BIT_THERM_WARN] = fault_in.thermal_warn[i];
        rdata_d[BIT_THERM_SHUT] = fault_in.thermal_shut[i];
      end
    end
    unique case (bus_req.addr)
      ADDR_QUICK: begin
        rdata_d[NUM_CH-1:0] = channel_summary_flag;
      end
      ADDR_DEVICE: begin
        rdata_d[BIT_SUPPLY_LOW] = ana_q.supply_low_flag;
      end
      ADDR_IO: begin
        // Undefined under low supply; zero is the safe choice.
        rdata_d[NUM_CH-1:0] = ana_q.supply_low_flag ? '0 :
          ana_q.half_supply_comparator;
      end
      ADDR_LED_CTRL: begin
        rdata_d[NUM_CH-1:0] = led_open_detect_enable_q;
      end
      ADDR_OFF_TEST: begin
        rdata_d[NUM_CH-1:0] = test_run;
      end
      ADDR_IRQ_STATUS: begin
        rdata_d[IRQ_W-1:0] = irq_status_q;
      end
      ADDR_IRQ_ENABLE: begin
        rdata_d[IRQ_W-1:0] = irq_enable_q;
      end
      default: begin
      end
    endcase
  end

  // Read data stand in the cycle after the strobe and only there.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= '0;
    end else if (bus_req.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign bus_rdata = rdata_q;

  // Interrupt events: a new open-load per channel, and any test finished.
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      irq_event[i] = (on_check[i] && on_below[i] && !on_open_flag_q[i]) ||
        (test_pass[i] && !off_state_open_flag_q[i]);
    end
    irq_event[BIT_IRQ_TEST_DONE] = |(test_pass | test_fail);
  end

  // Sticky status; an event in the clear cycle survives the clear, so a
  // handler that clears late never loses a fresh event.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_status_q <= '0;
    end else if (bus_req.wr && bus_req.addr == ADDR_IRQ_CLEAR) begin
      irq_status_q <= (irq_status_q & ~bus_req.wdata[IRQ_W-1:0]) |
        irq_event;
    end else begin
      irq_status_q <= irq_status_q | irq_event;
    end
  end

  // Interrupt enables, read back unchanged.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_enable_q <= RST_IRQ_ENABLE;
    end else if (bus_req.wr && bus_req.addr == ADDR_IRQ_ENABLE) begin
      irq_enable_q <= bus_req.wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_q & irq_enable_q);

endmodule
`default_nettype wire

// File: olsd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module olsd_checker
  import olsd_pkg::*;
#(
  parameter int OFF_TEST_LEN = 20
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire olsd_pkg::olsd_bus_req_t bus_req,
  input wire logic [olsd_pkg::DATA_W-1:0] bus_rdata,
  input wire olsd_pkg::olsd_analog_t analog_in,
  input wire olsd_pkg::olsd_fault_t fault_in,
  input wire olsd_pkg::olsd_chan_ctl_t chan_ctl,
  input wire logic [olsd_pkg::NUM_CH-1:0] test_drive,
  input wire logic irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Length of the current drive on channel zero; a window that never
  // ends would otherwise go unseen by a bounded property.
  int run_q;
  always_ff @(posedge core_clk) begin
    if (reset || !test_drive[0]) begin
      run_q <= 0;
    end else begin
      run_q <= run_q + 1;
    end
  end

  property p_rd_idle;
    !$past(bus_req.rd) |-> bus_rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmap;
    bus_req.rd && bus_req.addr == 5'h09 |=> bus_rdata == '0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
  property p_win;
    test_drive[0] |-> run_q < OFF_TEST_LEN;
  endproperty
  a_win: assert property (p_win) else $error("test window too long");
  property p_drop;
    (!analog_in.below_off_thr[0])[*3] |-> !test_drive[0];
  endproperty
  a_drop: assert property (p_drop) else $error("drive kept on load");
  property p_start;
    $rose(test_drive[0]) |-> $past(bus_req.wr &&
      bus_req.addr == ADDR_OFF_TEST && bus_req.wdata[0]);
  endproperty
  a_start: assert property (p_start) else $error("test not requested");
  property p_io;
    ($stable(analog_in.half_supply_comparator) &&
      !analog_in.supply_low_flag)[*3] ##0
      (bus_req.rd && bus_req.addr == ADDR_IO)
      |=> bus_rdata[4:0] == $past(analog_in.half_supply_comparator);
  endproperty
  a_io: assert property (p_io) else $error("output state wrong");
  property p_glob;
    (bus_req.rd && bus_req.addr >= ADDR_CH_FIRST &&
      bus_req.addr <= ADDR_CH_LAST) ##1 (bus_rdata[1:0] != 2'h0)
      |-> bus_rdata[BIT_GLOBAL_OPEN];
  endproperty
  a_glob: assert property (p_glob) else $error("global flag low");
  property p_led_ro;
    bus_req.rd && bus_req.addr == ADDR_LED_CTRL
      |=> !bus_rdata[BIT_LED_TRIGGER];
  endproperty
  a_led_ro: assert property (p_led_ro) else $error("trigger held");
  property p_irq;
    (bus_req.rd && bus_req.addr == ADDR_IRQ_ENABLE) ##1
      (bus_rdata[5:0] == 6'h00) |-> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq while masked");

  // Main scenarios that the bench should reach.
  c_test: cover property ($rose(test_drive[0]));
  c_irq: cover property ($rose(irq));
  c_io: cover property (bus_req.rd && bus_req.addr == ADDR_IO);
endmodule

bind olsd_diag olsd_checker #(.OFF_TEST_LEN(OFF_TEST_LEN)) u_chk (
  .core_clk(core_clk),
  .reset(reset),
  .bus_req(bus_req),
  .bus_rdata(bus_rdata),
  .analog_in(analog_in),
  .fault_in(fault_in),
  .chan_ctl(chan_ctl),
  .test_drive(test_drive),
  .irq(irq)
);
`default_nettype wire

// File: olsd_host.sv
`timescale 1ns/1ps
`default_nettype none
module olsd_host
  import olsd_pkg::*;
(
  input wire logic core_clk,
  output var olsd_pkg::olsd_bus_req_t bus_req,
  input wire logic [olsd_pkg::DATA_W-1:0] bus_rdata
);
  initial bus_req = '0;

  // One strobe cycle; address and data are scrambled when idle so that
  // a design sampling them late sees garbage, not a stale match.
  task automatic put(input logic [4:0] a, input logic [15:0] d,
                     input logic w);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge core_clk);
    bus_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  // Test enables and the LED trigger are only ever set from here.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    put(a, d, 1'b1);
  endtask

  // Read data stands only in the cycle after the strobe.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    put(a, 16'h0000, 1'b0);
    #1;
    d = bus_rdata;
  endtask
endmodule
`default_nettype wire

// File: openload_short_diagnostics_tb.sv
`timescale 1ns/1ps
`default_nettype none
module openload_short_diagnostics_tb;
  import olsd_pkg::*;
  localparam int LEN = 20;
  logic core_clk;
  logic reset;
  olsd_bus_req_t req;
  logic [15:0] rdata;
  olsd_analog_t a;
  olsd_chan_ctl_t c;
  olsd_fault_t f;
  logic [4:0] test_drive;
  logic irq;
  logic [15:0] v;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;

  olsd_host HOST (.core_clk(core_clk), .bus_req(req), .bus_rdata(rdata));
  olsd_diag #(.OFF_TEST_LEN(LEN)) DUT (.core_clk(core_clk),
    .reset(reset), .bus_req(req), .bus_rdata(rdata), .analog_in(a),
    .fault_in(f), .chan_ctl(c), .test_drive(test_drive), .irq(irq));

  always #50 core_clk = ~core_clk;

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic t_regs;
    HOST.rd(ADDR_LED_CTRL, v);
    chk("led_en", 16'h0000, v);
    HOST.rd(ADDR_IRQ_ENABLE, v);
    chk("irq_en", 16'h0000, v);
    HOST.rd(5'h09, v);
    chk("unmapped", 16'h0000, v);
    $display("test regs done");
  endtask

  // A passing test on channel zero, then a failing one.
  task automatic t_off;
    a.below_off_thr[0] <= 1'b1;
    cyc(3);
    HOST.wr(ADDR_IRQ_ENABLE, 16'h0001);
    HOST.wr(ADDR_OFF_TEST, 16'h0001);
    #1 chk("drive_on", 16'h0001, {11'h0, test_drive});
    cyc(LEN + 2);
    chk("drive_end", 16'h0000, {11'h0, test_drive});
    HOST.rd(ADDR_IRQ_STATUS, v);
    chk("irq_st", 16'h0021, v);
    chk("irq_hi", 16'h0001, {15'h0, irq});
    HOST.wr(ADDR_IRQ_CLEAR, 16'h003f);
    #1 chk("irq_lo", 16'h0000, {15'h0, irq});
    HOST.rd(ADDR_QUICK, v);
    chk("quick", 16'h0101, v & 16'h0101);
    HOST.rd(ADDR_CH_FIRST, v);
    chk("off_pass", 16'h0101, v & 16'h0103);
    HOST.wr(ADDR_OFF_TEST, 16'h0001);
    cyc(3);
    HOST.rd(ADDR_CH_FIRST, v);
    chk("off_hold", 16'h0001, v & 16'h0001);
    HOST.rd(ADDR_OFF_TEST, v);
    chk("off_run", 16'h0001, v);
    a.below_off_thr[0] <= 1'b0;
    cyc(4);
    chk("drive_cut", 16'h0000, {11'h0, test_drive});
    HOST.rd(ADDR_CH_FIRST, v);
    chk("off_fail", 16'h0000, v & 16'h0001);
    HOST.rd(ADDR_QUICK, v);
    chk("glob_clear", 16'h0000, v & 16'h0101);
    $display("test off done");
  endtask

  // Normal threshold on channel two, latched until gone and read; an
  // off test asked for while that output is on must not start.
  task automatic t_on;
    c.on[2] <= 1'b1;
    c.full_on[2] <= 1'b1;
    a.below_on_thr[2] <= 1'b1;
    a.below_off_thr <= 5'h04;
    cyc(4);
    HOST.rd(5'h04, v);
    chk("on_open", 16'h0102, v & 16'h0103);
    HOST.wr(ADDR_OFF_TEST, 16'h0004);
    #1 chk("off_refused", 16'h0000, {11'h0, test_drive});
    a.below_on_thr[2] <= 1'b0;
    cyc(4);
    HOST.rd(5'h04, v);
    chk("on_latch", 16'h0002, v & 16'h0002);
    HOST.rd(5'h04, v);
    chk("on_clear", 16'h0000, v & 16'h0002);
    $display("test on done");
  endtask

  // LED threshold: on request at full duty, at turn-off under PWM.
  task automatic t_led;
    HOST.wr(ADDR_LED_CTRL, 16'h0018);
    c.on[3] <= 1'b1;
    c.full_on[3] <= 1'b1;
    c.on[4] <= 1'b1;
    c.duty[4] <= 8'h11;
    a.below_led_thr <= 5'h18;
    cyc(4);
    HOST.rd(5'h05, v);
    chk("led_wait", 16'h0000, v & 16'h0002);
    HOST.wr(ADDR_LED_CTRL, 16'h0038);
    cyc(2);
    HOST.rd(5'h05, v);
    chk("led_trig", 16'h0002, v & 16'h0002);
    HOST.rd(ADDR_LED_CTRL, v);
    chk("led_ctrl", 16'h0018, v);
    @(posedge core_clk) c.turn_off[4] <= 1'b1;
    @(posedge core_clk) c.turn_off[4] <= 1'b0;
    HOST.rd(5'h06, v);
    chk("pwm_short", 16'h0000, v & 16'h0002);
    c.freq_range <= FREQ_RANGE_HIGH;
    @(posedge core_clk) c.turn_off[4] <= 1'b1;
    @(posedge core_clk) c.turn_off[4] <= 1'b0;
    HOST.rd(5'h06, v);
    chk("pwm_open", 16'h0002, v & 16'h0002);
    $display("test led done");
  endtask

  // Neighbouring fault flags feed the summary and global overload bits.
  task automatic t_fault;
    f.thermal_warn[1] <= 1'b1;
    cyc(2);
    HOST.rd(ADDR_QUICK, v);
    chk("sum_warn", 16'h0002, v & 16'h0202);
    f.thermal_shut[1] <= 1'b1;
    cyc(2);
    HOST.rd(5'h03, v);
    chk("overload", 16'h0260, v & 16'h0260);
    $display("test fault done");
  endtask

  task automatic t_io;
    a.half_supply_comparator <= 5'h15;
    cyc(4);
    HOST.rd(ADDR_IO, v);
    chk("io", 16'h0015, v);
    a.supply_low_flag <= 1'b1;
    cyc(4);
    HOST.rd(ADDR_IO, v);
    chk("io_low", 16'h0000, v);
    HOST.rd(ADDR_DEVICE, v);
    chk("dev_low", 16'h0404, v & 16'h0404);
    $display("test io done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hung handshake ends the run here rather than never.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      finish_test();
    end
  end

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    a = '0;
    c = '0;
    f = '0;
    cyc(5);
    reset <= 1'b0;
    t_regs();
    t_off();
    t_on();
    t_led();
    t_fault();
    t_io();
    finish_test();
  end
endmodule
`default_nettype wire
